/* logic/tcma_pkg.sv */
package tcma_pkg;
   // ----------------------------------------
   // host port geometry
   // ----------------------------------------
   localparam int ADDR_W = 14;
   localparam int DATA_W = 16;
   localparam int MSEL_POS = 13;
   localparam int STREAM_HI = 12;
   localparam int STREAM_LO = 8;
   localparam int CHAN_HI = 7;
   localparam int CHAN_LO = 0;
   localparam int NSTREAM = 16;
   localparam int NCHAN = 256;
   localparam int MEM_DEPTH = 4096;
   // ----------------------------------------
   // control register
   // ----------------------------------------
   localparam logic [13:0] CTRL_OFFSET = 14'h0000;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam int CTRL_MSEL_HI = 1;
   localparam int CTRL_MSEL_LO = 0;
   localparam int CTRL_VARIABLE_DELAY_ENABLE_POS = 2;
   localparam int CTRL_RATE_HI = 4;
   localparam int CTRL_RATE_LO = 3;
   // ----------------------------------------
   // connection entry low fields
   // ----------------------------------------
   localparam int CE_RSV15_POS = 15;
   localparam int CE_VDLY_POS = 14;
   localparam int CE_RSV13_POS = 13;
   localparam int CE_SSTR_HI = 12;
   localparam int CE_SSTR_LO = 9;
   localparam int CE_SCH_HI = 8;
   localparam int CE_SCH_LO = 1;
   localparam int CE_MODE_POS = 0;
   localparam int CE_PCC_HI = 2;
   localparam int CE_PCC_LO = 1;
   localparam int CE_MSG_HI = 10;
   localparam int CE_MSG_LO = 3;
   localparam logic [15:0] MEM_RESET = 16'h0000;

   typedef enum logic [1:0] {
      TCMA_MEM_DATA = 2'h0,
      TCMA_MEM_CEL = 2'h1,
      TCMA_MEM_CEH = 2'h2,
      TCMA_MEM_NONE = 2'h3
   } tcma_mem_t;

   typedef enum logic [1:0] {
      TCMA_RATE_2M = 2'h0,
      TCMA_RATE_4M = 2'h1,
      TCMA_RATE_8M = 2'h2,
      TCMA_RATE_16M = 2'h3
   } tcma_rate_t;

   typedef enum logic [1:0] {
      TCMA_PCC_TRISTATE = 2'h0,
      TCMA_PCC_MESSAGE = 2'h1,
      TCMA_PCC_RSV2 = 2'h2,
      TCMA_PCC_RSV3 = 2'h3
   } tcma_pcc_t;

   // ----------------------------------------
   // host access states
   // ----------------------------------------
   typedef enum logic [1:0] {
      TCMA_IDLE = 2'h0,
      TCMA_ACCESS = 2'h1,
      TCMA_DONE = 2'h3
   } tcma_state_t;
endpackage

/* logic/tcma_entry_if.sv */
`timescale 1ns/1ps
interface tcma_entry_if;
   logic [15:0] entry;
   logic special;
   logic var_delay;
   logic [3:0] src_stream;
   logic [7:0] src_channel;
   logic [1:0] pcc;
   logic [7:0] msg;
   logic rsv_viol;
   modport src (output entry, input special, var_delay, src_stream, src_channel, pcc, msg,
      rsv_viol);
   modport dec (input entry, output special, var_delay, src_stream, src_channel, pcc, msg,
      rsv_viol);
endinterface

/* logic/tcma_entry_decode.sv */
`timescale 1ns/1ps
module tcma_entry_decode
   import tcma_pkg::*;
(
   tcma_entry_if.dec ent
);
   // ----------------------------------------
   // connection entry low decode
   // ----------------------------------------
   always_comb begin
      ent.special = ent.entry[CE_MODE_POS];
      ent.var_delay = ~ent.entry[CE_MODE_POS] & ent.entry[CE_VDLY_POS];
      ent.src_stream = ent.entry[CE_SSTR_HI:CE_SSTR_LO];
      ent.src_channel = ent.entry[CE_SCH_HI:CE_SCH_LO];
      ent.pcc = ent.entry[CE_PCC_HI:CE_PCC_LO];
      ent.msg = ent.entry[CE_MSG_HI:CE_MSG_LO];
      // software slip only flagged, never corrected
      ent.rsv_viol = ~ent.entry[CE_MODE_POS] &
         (ent.entry[CE_RSV15_POS] | ent.entry[CE_RSV13_POS]);
   end
endmodule

/* logic/tcma_access.sv */
`timescale 1ns/1ps
// What this block does
// - memory-space bit high sends host accesses to memories, not control registers
// - control bits 1-0 pick data memory, entry low or entry high
// - valid channels depend on rate: 32, 64, 128 or 256
// - entry bits 12-9 give the source stream
// - entry bits 8-1 give the source channel
// - entry bit 0 low means normal switching with source fields
// - entry bit 0 high selects tristate or message mode by control bits
module tcma_access
   import tcma_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [tcma_pkg::ADDR_W-1:0] addr,
   input wire logic [tcma_pkg::DATA_W-1:0] wdata,
   output logic [tcma_pkg::DATA_W-1:0] rdata,
   output logic rdata_oe,
   output logic ack,
   input wire logic [tcma_pkg::ADDR_W-1:0] lookup_addr,
   output logic lookup_special,
   output logic lookup_var_delay,
   output logic [3:0] lookup_src_stream,
   output logic [7:0] lookup_src_channel,
   output logic [1:0] lookup_pcc,
   output logic [7:0] lookup_msg,
   output logic range_error,
   output logic reserved_error,
   output logic vardelay_error
);
   import tcma_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] strb_s1_q, strb_s2_q;
   logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
   logic [DATA_W-1:0] wd_s1_q, wd_s2_q;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         strb_s1_q <= 3'h7;
         strb_s2_q <= 3'h7;
         addr_s1_q <= '0;
         addr_s2_q <= '0;
         wd_s1_q <= '0;
         wd_s2_q <= '0;
      end else begin
         strb_s1_q <= {cs_n, rd_n, wr_n};
         strb_s2_q <= strb_s1_q;
         addr_s1_q <= addr;
         addr_s2_q <= addr_s1_q;
         wd_s1_q <= wdata;
         wd_s2_q <= wd_s1_q;
      end
   end

   logic req_rd, req_wr;
   assign req_rd = ~strb_s2_q[2] & ~strb_s2_q[1];
   assign req_wr = ~strb_s2_q[2] & ~strb_s2_q[0];

   // ----------------------------------------
   // access sequencer
   // ----------------------------------------
   tcma_state_t state_q, state_d;
   always_comb begin
      state_d = state_q;
      case (state_q)
         TCMA_IDLE: if (req_rd | req_wr) state_d = TCMA_ACCESS;
         TCMA_ACCESS: state_d = TCMA_DONE;
         TCMA_DONE: if (!(req_rd | req_wr)) state_d = TCMA_IDLE;
         default: state_d = TCMA_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) state_q <= TCMA_IDLE;
      else state_q <= state_d;
   end
   logic do_acc;
   assign do_acc = (state_q == TCMA_ACCESS);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic [11:0] mem_index(input logic [ADDR_W-1:0] a);
      mem_index = {a[STREAM_HI-1:STREAM_LO], a[CHAN_HI:CHAN_LO]};
   endfunction

   function automatic logic chan_ok(input logic [7:0] ch, input tcma_rate_t r);
      case (r)
         TCMA_RATE_2M: chan_ok = (ch[7:5] == 3'h0);
         TCMA_RATE_4M: chan_ok = (ch[7:6] == 2'h0);
         TCMA_RATE_8M: chan_ok = ~ch[7];
         default: chan_ok = 1'b1;
      endcase
   endfunction

   logic [15:0] ctrl_q;
   tcma_rate_t rate;
   tcma_mem_t msel;
   assign rate = tcma_rate_t'(ctrl_q[CTRL_RATE_HI:CTRL_RATE_LO]);
   assign msel = tcma_mem_t'(ctrl_q[CTRL_MSEL_HI:CTRL_MSEL_LO]);

   logic mem_space, a_valid;
   logic [11:0] idx;
   assign mem_space = addr_s2_q[MSEL_POS];
   // stream field bit 12 must be zero; only 16 streams
   assign a_valid = ~addr_s2_q[STREAM_HI] & chan_ok(addr_s2_q[CHAN_HI:CHAN_LO], rate);
   assign idx = mem_index(addr_s2_q);

   // ----------------------------------------
   // control register and memories
   // ----------------------------------------
   logic [15:0] dmem_q [MEM_DEPTH];
   logic [15:0] cel_q [MEM_DEPTH];
   logic [15:0] ceh_q [MEM_DEPTH];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) ctrl_q <= CTRL_RESET;
      else if (do_acc && req_wr && !mem_space && addr_s2_q == CTRL_OFFSET)
         ctrl_q <= wd_s2_q;
   end

   logic wr_mem;
   assign wr_mem = do_acc & req_wr & mem_space & a_valid;

   // data and entry-high storage unreset to spare reset fan-out
   always_ff @(posedge ref_clk) begin
      if (wr_mem && msel == TCMA_MEM_DATA) dmem_q[idx] <= wd_s2_q;
   end
   // entry low is reset: the lookup reads it on every cycle, never unknown
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            cel_q[i] <= MEM_RESET;
         end
      end else if (wr_mem && msel == TCMA_MEM_CEL) begin
         cel_q[idx] <= wd_s2_q;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (wr_mem && msel == TCMA_MEM_CEH) ceh_q[idx] <= wd_s2_q;
   end

   // ----------------------------------------
   // read path and status
   // ----------------------------------------
   logic [15:0] rd_d;
   always_comb begin
      rd_d = 16'h0000;
      if (!mem_space) begin
         if (addr_s2_q == CTRL_OFFSET) rd_d = ctrl_q;
      end else if (a_valid) begin
         case (msel)
            TCMA_MEM_DATA: rd_d = dmem_q[idx];
            TCMA_MEM_CEL: rd_d = cel_q[idx];
            TCMA_MEM_CEH: rd_d = ceh_q[idx];
            default: rd_d = 16'h0000;
         endcase
      end
   end

   tcma_entry_if wr_ent ();
   assign wr_ent.entry = wd_s2_q;
   tcma_entry_decode u_wr_dec (.ent(wr_ent));

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rdata <= 16'h0000;
         range_error <= 1'b0;
         reserved_error <= 1'b0;
         vardelay_error <= 1'b0;
      end else if (do_acc) begin
         if (req_rd) rdata <= rd_d;
         range_error <= mem_space & ~a_valid;
         reserved_error <= wr_mem & (msel == TCMA_MEM_CEL) & wr_ent.rsv_viol;
         // variable delay without enable: software slip, flagged
         vardelay_error <= wr_mem & (msel == TCMA_MEM_CEL) & wr_ent.var_delay &
            ~ctrl_q[CTRL_VARIABLE_DELAY_ENABLE_POS];
      end
   end
   assign ack = (state_q == TCMA_DONE);
   assign rdata_oe = ack & req_rd;

   // ----------------------------------------
   // switching-side lookup
   // ----------------------------------------
   logic [ADDR_W-1:0] lk_q;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) lk_q <= '0;
      else lk_q <= lookup_addr;
   end
   tcma_entry_if lk_ent ();
   assign lk_ent.entry = cel_q[mem_index(lk_q)];
   tcma_entry_decode u_lk_dec (.ent(lk_ent));

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lookup_special <= 1'b0;
         lookup_var_delay <= 1'b0;
         lookup_src_stream <= 4'h0;
         lookup_src_channel <= 8'h00;
         lookup_pcc <= 2'h0;
         lookup_msg <= 8'h00;
      end else begin
         lookup_special <= lk_ent.special;
         lookup_var_delay <= lk_ent.var_delay & ctrl_q[CTRL_VARIABLE_DELAY_ENABLE_POS];
         lookup_src_stream <= lk_ent.src_stream;
         lookup_src_channel <= lk_ent.src_channel;
         lookup_pcc <= lk_ent.pcc;
         lookup_msg <= lk_ent.msg;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_mem_no_ctrl: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (do_acc && req_wr && mem_space) |=> $stable(ctrl_q))
      else $error("memory access changed control register");
   a_range_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (do_acc && mem_space && rate == TCMA_RATE_2M && addr_s2_q[5])
      |=> range_error)
      else $error("out of range channel not flagged");
   a_cel_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wr_mem && msel == TCMA_MEM_CEL) |=> cel_q[$past(idx)] == $past(wd_s2_q))
      else $error("entry low write lost");
   a_ack_seq: assert property (@(posedge ref_clk) disable iff (!reset_n)
      do_acc |=> ack)
      else $error("ack missing after access");
   a_src_fields: assert property (@(posedge ref_clk) disable iff (!reset_n)
      1'b1 |=> lookup_src_stream == $past(lk_ent.entry[12:9])
         && lookup_src_channel == $past(lk_ent.entry[8:1]))
      else $error("source field decode wrong");
   a_mode_bit: assert property (@(posedge ref_clk) disable iff (!reset_n)
      1'b1 |=> lookup_special == $past(lk_ent.entry[0]))
      else $error("entry mode decode wrong");
   a_var_delay: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lookup_var_delay |-> $past(lk_ent.entry[14]) && !$past(lk_ent.entry[0]))
      else $error("variable delay without select");
   a_stream_idx: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (do_acc && mem_space && addr_s2_q[STREAM_HI]) |=> range_error)
      else $error("stream beyond 15 not refused");
endmodule

/* verif/tcma_host_model.sv */
`timescale 1ns/1ps
module tcma_host_model
   import tcma_pkg::*;
(
   input wire logic ref_clk,
   input wire logic ack,
   input wire logic [tcma_pkg::DATA_W-1:0] rdata,
   input wire logic rdata_oe,
   output logic oe,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [tcma_pkg::ADDR_W-1:0] addr,
   output logic [tcma_pkg::DATA_W-1:0] wdata,
   output logic hang
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 14'h0000;
      wdata = 16'h0000;
      hang = 1'b0;
      oe = 1'b0;
   end

   // strobes held until ack seen high, then released with the bus inverted at once; ack then awaited low
   task automatic access(input logic wr, input logic [13:0] a, input logic [15:0] d,
      output logic [15:0] q);
      int n;
      n = 0;
      addr = a;
      wdata = d;
      cs_n = 1'b0;
      rd_n = wr;
      wr_n = !wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdata;
      oe = rdata_oe;
      if (ack !== 1'b1) hang = 1'b1;
      #1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = ~a;
      wdata = ~d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b0 && n < 40);
      #1;
      if (ack !== 1'b0) hang = 1'b1;
   endtask

   // memory space always reached with the space bit high
   task automatic mem(input logic wr, input logic [3:0] s, input logic [7:0] c,
      input logic [15:0] d, output logic [15:0] q);
      access(wr, {1'b1, 1'b0, s, c}, d, q);
   endtask
endmodule

/* verif/tdm_connection_memory_access_tb_top.sv */
`timescale 1ns/1ps
module tdm_connection_memory_access_tb_top;
   import tcma_pkg::*;
   logic ref_clk, reset_n, cs_n, rd_n, wr_n, rdata_oe, ack, hang, special, var_dly;
   logic [13:0] addr, lookup_addr;
   logic [15:0] wdata, rdata, q;
   logic [3:0] src_s;
   logic [7:0] src_c, msg;
   logic [1:0] pcc;
   logic range_error, reserved_error, vardelay_error, oe;
   int bad_count = 0;
   int n_checks = 0;

   tcma_access u_tcma_access (.ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata), .rdata(rdata),
      .rdata_oe(rdata_oe), .ack(ack), .lookup_addr(lookup_addr),
      .lookup_special(special), .lookup_var_delay(var_dly), .lookup_src_stream(src_s),
      .lookup_src_channel(src_c), .lookup_pcc(pcc), .lookup_msg(msg),
      .range_error(range_error), .reserved_error(reserved_error),
      .vardelay_error(vardelay_error));
   tcma_host_model u_tcma_host_model (.ref_clk(ref_clk), .ack(ack), .rdata(rdata),
      .rdata_oe(rdata_oe), .oe(oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .wdata(wdata), .hang(hang));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      if (bad_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge hang) begin
      bad_count++;
      report_and_stop;
   end

   task automatic ctl(input logic wr, input logic [13:0] a, input logic [15:0] d);
      u_tcma_host_model.access(wr, a, d, q);
   endtask

   task automatic mw(input logic [3:0] s, input logic [7:0] c, input logic [15:0] d);
      u_tcma_host_model.mem(1'b1, s, c, d, q);
      check({15'h0000, oe}, 16'h0000);
   endtask

   task automatic mr(input logic [3:0] s, input logic [7:0] c, input logic [15:0] exp);
      u_tcma_host_model.mem(1'b0, s, c, 16'h0000, q);
      check(q, exp);
      check({15'h0000, oe}, 16'h0001);
   endtask

   // decode shows two cycles after the lookup address
   task automatic look(input logic [3:0] s, input logic [7:0] c);
      lookup_addr = {1'b1, 1'b0, s, c};
      @(posedge ref_clk);
      @(posedge ref_clk);
      #1;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_ctrl;
      check({ack, range_error, 14'h0000}, 16'h0000);
      ctl(1'b0, CTRL_OFFSET, 16'h0000);
      check(q, CTRL_RESET);
      ctl(1'b1, CTRL_OFFSET, 16'h001D);
      ctl(1'b0, CTRL_OFFSET, 16'h0000);
      check(q, 16'h001D);
      ctl(1'b1, 14'h0010, 16'h0003);
      ctl(1'b0, 14'h0010, 16'h0000);
      check(q, 16'h0000);
   endtask

   task automatic t_normal;
      mw(4'hF, 8'hFF, 16'h534A);
      mw(4'h0, 8'h00, 16'h1FFE);
      check({14'h0000, reserved_error, vardelay_error}, 16'h0000);
      mr(4'hF, 8'hFF, 16'h534A);
      look(4'hF, 8'hFF);
      check({2'b00, special, var_dly, src_s, src_c}, 16'h19A5);
      look(4'h0, 8'h00);
      check({2'b00, special, var_dly, src_s, src_c}, 16'h0FFF);
      ctl(1'b1, CTRL_OFFSET, 16'h0019);
      look(4'hF, 8'hFF);
      check({2'b00, special, var_dly, src_s, src_c}, 16'h09A5);
      ctl(1'b1, CTRL_OFFSET, 16'h001D);
   endtask

   task automatic t_special;
      for (int i = 0; i < 2; i++) begin
         mw(4'h3, 8'h07, {5'h00, 8'h3C, i[1:0], 1'b1});
         look(4'h3, 8'h07);
         check({13'h0000, special, pcc}, {13'h0000, 1'b1, i[1:0]});
      end
      check({8'h00, msg}, 16'h003C);
   endtask

   task automatic t_select;
      ctl(1'b1, CTRL_OFFSET, 16'h0018);
      mw(4'hF, 8'hFF, 16'hBEEF);
      ctl(1'b1, CTRL_OFFSET, 16'h001A);
      mw(4'hF, 8'hFF, 16'h1234);
      mr(4'hF, 8'hFF, 16'h1234);
      ctl(1'b1, CTRL_OFFSET, 16'h0018);
      mr(4'hF, 8'hFF, 16'hBEEF);
      ctl(1'b1, CTRL_OFFSET, 16'h001B);
      mr(4'hF, 8'hFF, 16'h0000);
      ctl(1'b1, CTRL_OFFSET, 16'h0019);
      mr(4'hF, 8'hFF, 16'h534A);
   endtask

   // last legal channel per rate, then the first one past it for the three lower rates
   task automatic t_range;
      logic [7:0] last;
      for (int r = 0; r < 4; r++) begin
         last = 8'((32 << r) - 1);
         ctl(1'b1, CTRL_OFFSET, {11'h000, r[1:0], 3'h5});
         mw(4'h2, last, 16'h0002);
         check({15'h0000, range_error}, 16'h0000);
         mr(4'h2, last, 16'h0002);
         if (r < 3) begin
            mw(4'h2, last + 8'h01, 16'h0004);
            check({15'h0000, range_error}, 16'h0001);
            mr(4'h2, last + 8'h01, 16'h0000);
         end
      end
      // stream field bit 12 set: write refused, location keeps its reset value
      ctl(1'b1, 14'h3207, 16'h0004);
      check({15'h0000, range_error}, 16'h0001);
      mr(4'h2, 8'h07, MEM_RESET);
   endtask

   initial begin
      reset_n = 1'b0;
      lookup_addr = 14'h0000;
      repeat (12) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      t_ctrl;
      t_normal;
      t_special;
      t_select;
      t_range;
      report_and_stop;
   end
endmodule
